// >>> dap_defines.svh
/*
 Timing-free constants of the arithmetic datapath: widths, shift limits, reset values.
 Assumes inclusion by bare name from the package and the datapath module.
*/
`ifndef DAP_DEFINES_SVH
`define DAP_DEFINES_SVH
`define DAP_WORD_W 16
`define DAP_ACC_W 32
`define DAP_SHIFT_MAX 5'h10
`define DAP_ACC_RST 32'h00000000
`define DAP_PROD_RST 32'h00000000
`define DAP_OPND_RST 16'h0000
`define DAP_NORM_BIT_HI 31
`define DAP_NORM_BIT_LO 30
`define DAP_SXM_BIT 10
`endif

// >>> dap_pkg.sv
/*
 Types for the arithmetic datapath: ALU op codes, operand select, product shift modes,
 the command struct and the state struct. Assumes dap_defines.svh is on the include path.
*/
`include "dap_defines.svh"
package dap_pkg;
  typedef enum logic [3:0] {
    DAP_OP_NOP = 4'h0,
    DAP_OP_LOAD = 4'h1,
    DAP_OP_ADD = 4'h2,
    DAP_OP_SUB = 4'h3,
    DAP_OP_AND = 4'h4,
    DAP_OP_OR = 4'h5,
    DAP_OP_XOR = 4'h6,
    DAP_OP_ABS = 4'h7,
    DAP_OP_NORM = 4'h8,
    DAP_OP_ZERO = 4'h9
  } dap_alu_op_e;

  typedef enum logic {
    DAP_SRC_SHIFTER = 1'b0,
    DAP_SRC_PRODUCT = 1'b1
  } dap_src_e;

  // Product shift modes: none, left 1, left 4, right 6
  typedef enum logic [1:0] {
    DAP_PSH_NONE = 2'h0,
    DAP_PSH_L1 = 2'h1,
    DAP_PSH_L4 = 2'h2,
    DAP_PSH_R6 = 2'h3
  } dap_pshift_e;

  typedef struct packed {
    logic alu_en;
    dap_alu_op_e alu_op;
    dap_src_e src_sel;
    logic [4:0] shift_amt;
    logic load_opnd;
    logic mult_en;
    logic mult_signed;
    logic [1:0] product_shift_select;
    logic store_en;
    logic store_upper;
    logic [2:0] store_shift;
    logic bit_test_en;
    logic [3:0] bit_sel;
  } dap_cmd_s;

  typedef struct packed {
    logic [`DAP_ACC_W-1:0] acc;
    logic carry;
    logic [`DAP_ACC_W-1:0] product_holding_reg;
    logic [`DAP_WORD_W-1:0] multiplier_operand_reg;
    logic [`DAP_WORD_W-1:0] store_data;
    logic store_valid;
    logic bit_test;
    logic norm_done;
  } dap_state_s;
endpackage

// >>> dap_datapath.sv
/*
 Arithmetic datapath of a 16-bit fixed-point core: 32-bit ALU and accumulator,
 input scaling shifter, 16x16 multiplier with operand and product registers,
 product output shifter, split accumulator stores and bit test.
 Assumes the instruction decoder drives cmd and bus words synchronously to clock.
*/
// How it works
// - ALU takes one operand from the accumulator in every op except LOAD and ZERO.
// - Second operand chosen by instruction: shifted product or scaling shifter.
// - Every ALU result is written back to the accumulator.
// - ALU operations complete in one clock cycle.
// - Accumulator low half is offered as branch target address.
// - Normalize step shifts a non-zero accumulator left while top two bits agree.
// - Selected bit of a data word is tested and offered as branch condition.
// - Accumulator is stored as separate upper and lower 16-bit words.
// - Store path shifts the value but leaves the accumulator untouched.
// - Scaling shifter takes a 16-bit bus word, gives 32 bits to the ALU.
// - Scaling shift is 0 to 16 bits left, amount from instruction.
// - Vacated low bits of the scaling shifter are zero.
// - Upper bits sign-extend when sign_extend_enable is set, else zero.
// - Multiplier forms signed or unsigned 32-bit product in one cycle.
// - Operand holding register supplies one multiplier input.
// - Product is captured in a 32-bit register that feeds the ALU.
// - Multiply and accumulate proceed together in a single cycle.
// - Product output passes through a four-mode shifter before the ALU.
// - A 2-bit code selects the product shift mode.
`timescale 1ns/1ns
`include "dap_defines.svh"
module dap_datapath (
  input wire logic clock,
  input wire logic nrst,
  input wire logic clk_en,
  input wire dap_pkg::dap_cmd_s cmd,
  input wire logic [15:0] data_bus_in,
  input wire logic [15:0] prog_bus_in,
  input wire logic [15:0] status_word_one,
  output logic [31:0] accum,
  output logic [15:0] branch_target,
  output logic carry,
  output logic [31:0] product_out,
  output logic [15:0] operand_out,
  output logic [15:0] store_data,
  output logic store_valid,
  output logic bit_test,
  output logic norm_done
);
  import dap_pkg::*;

  localparam int SXM_BIT = `DAP_SXM_BIT;

  dap_state_s st_q;
  dap_state_s st_d;

  // Sign or zero extension of a bus word to accumulator width
  function automatic logic [31:0] extend_word(input logic [15:0] w, input logic sx);
    logic [31:0] r;
    if (sx) begin
      r = {{16{w[15]}}, w};
    end else begin
      r = {16'h0000, w};
    end
    return r;
  endfunction

  // Shift amounts above sixteen are held at sixteen
  function automatic logic [4:0] clamp_shift(input logic [4:0] amt);
    logic [4:0] r;
    if (amt > `DAP_SHIFT_MAX) begin
      r = `DAP_SHIFT_MAX;
    end else begin
      r = amt;
    end
    return r;
  endfunction

  // Scaling shifter: 16-bit word to 32 bits, zero below, sign or zero above
  function automatic logic [31:0] scale_word(input logic [15:0] w, input logic [4:0] amt,
                                             input logic sx);
    return extend_word(w, sx) << clamp_shift(amt);
  endfunction

  // Product output shifter: none, left 1, left 4, arithmetic right 6
  function automatic logic [31:0] prod_shift(input logic [31:0] p, input logic [1:0] m);
    logic [31:0] r;
    case (m)
      DAP_PSH_NONE: begin
        r = p;
      end
      DAP_PSH_L1: begin
        r = {p[30:0], 1'b0};
      end
      DAP_PSH_L4: begin
        r = {p[27:0], 4'h0};
      end
      DAP_PSH_R6: begin
        r = {{6{p[31]}}, p[31:6]};
      end
      default: begin
        r = p;
      end
    endcase
    return r;
  endfunction

  // Add with the carry out in the top bit
  function automatic logic [32:0] add_carry(input logic [31:0] a, input logic [31:0] b);
    return {1'b0, a} + {1'b0, b};
  endfunction

  // Subtract; the top bit is set when no borrow occurred
  function automatic logic [32:0] sub_borrow(input logic [31:0] a, input logic [31:0] b);
    logic [32:0] d;
    d = {1'b0, a} - {1'b0, b};
    return {~d[32], d[31:0]};
  endfunction

  // Absolute value; the most negative value maps to itself
  function automatic logic [31:0] abs_value(input logic [31:0] a);
    logic [31:0] r;
    if (a[31]) begin
      r = 32'h00000000 - a;
    end else begin
      r = a;
    end
    return r;
  endfunction

  // True while the value is non-zero and one more left shift keeps it in range
  function automatic logic norm_wanted(input logic [31:0] a);
    logic same_top;
    logic non_zero;
    same_top = a[`DAP_NORM_BIT_HI] == a[`DAP_NORM_BIT_LO];
    non_zero = a != 32'h00000000;
    return same_top && non_zero;
  endfunction

  // Bitwise operations of the ALU
  function automatic logic [31:0] alu_logic(input dap_alu_op_e op, input logic [31:0] a,
                                            input logic [31:0] b);
    logic [31:0] r;
    case (op)
      DAP_OP_AND: begin
        r = a & b;
      end
      DAP_OP_OR: begin
        r = a | b;
      end
      DAP_OP_XOR: begin
        r = a ^ b;
      end
      default: begin
        r = a;
      end
    endcase
    return r;
  endfunction

  // Signed or unsigned 16x16 product; operands widened to 32 bits first
  function automatic logic [31:0] mult16(input logic [15:0] a, input logic [15:0] b,
                                         input logic sgn);
    logic [31:0] wa;
    logic [31:0] wb;
    if (sgn) begin
      wa = {{16{a[15]}}, a};
      wb = {{16{b[15]}}, b};
    end else begin
      wa = {16'h0000, a};
      wb = {16'h0000, b};
    end
    return wa * wb;
  endfunction

  // One accumulator half after the store shifter; the accumulator is not written
  function automatic logic [15:0] store_half(input logic [31:0] a, input logic [2:0] sh,
                                             input logic upper);
    logic [31:0] s;
    logic [15:0] r;
    s = a << sh;
    if (upper) begin
      r = s[31:16];
    end else begin
      r = s[15:0];
    end
    return r;
  endfunction

  // Bit select counts from the top: 0 picks bit 15, 15 picks bit 0
  function automatic logic pick_bit(input logic [15:0] w, input logic [3:0] sel);
    logic [3:0] idx;
    idx = 4'hF - sel;
    return w[idx];
  endfunction

  logic [31:0] op_b;
  logic [32:0] sum;
  logic [15:0] store_word;
  logic [31:0] prod_full;
  logic [15:0] mult_a;
  logic [15:0] mult_b;

  // Next state: ALU, multiplier, store path and bit test all act in one cycle
  always_comb begin
    st_d = st_q;
    st_d.store_valid = 1'b0;
    // Second ALU operand: shifted product or scaled data word
    if (cmd.src_sel == DAP_SRC_PRODUCT) begin
      op_b = prod_shift(st_q.product_holding_reg, cmd.product_shift_select);
    end else begin
      op_b = scale_word(data_bus_in, cmd.shift_amt, status_word_one[SXM_BIT]);
    end
    sum = 33'h000000000;
    if (cmd.alu_en) begin
      // One operand is the accumulator except for LOAD and ZERO; result always lands in it
      case (cmd.alu_op)
        DAP_OP_LOAD: begin
          st_d.acc = op_b;
        end
        DAP_OP_ADD: begin
          sum = add_carry(st_q.acc, op_b);
          st_d.acc = sum[31:0];
          st_d.carry = sum[32];
        end
        DAP_OP_SUB: begin
          sum = sub_borrow(st_q.acc, op_b);
          st_d.acc = sum[31:0];
          st_d.carry = sum[32];
        end
        DAP_OP_AND, DAP_OP_OR, DAP_OP_XOR: begin
          st_d.acc = alu_logic(cmd.alu_op, st_q.acc, op_b);
        end
        DAP_OP_ABS: begin
          st_d.acc = abs_value(st_q.acc);
        end
        DAP_OP_NORM: begin
          // One normalize step per command; done when top bits differ or acc is zero
          if (norm_wanted(st_q.acc)) begin
            st_d.acc = {st_q.acc[30:0], 1'b0};
            st_d.norm_done = 1'b0;
          end else begin
            st_d.norm_done = 1'b1;
          end
        end
        DAP_OP_ZERO: begin
          st_d.acc = 32'h00000000;
        end
        default: begin
          st_d.acc = st_q.acc;
        end
      endcase
    end

    // Multiplier runs alongside the ALU so a MAC completes each cycle
    mult_a = st_q.multiplier_operand_reg;
    mult_b = prog_bus_in;
    prod_full = mult16(mult_a, mult_b, cmd.mult_signed);
    if (cmd.mult_en) begin
      st_d.product_holding_reg = prod_full;
    end
    if (cmd.load_opnd) begin
      st_d.multiplier_operand_reg = data_bus_in;
    end

    // Store path shifts a copy; accumulator itself is not touched
    store_word = store_half(st_q.acc, cmd.store_shift, cmd.store_upper);
    if (cmd.store_en) begin
      st_d.store_data = store_word;
      st_d.store_valid = 1'b1;
    end

    if (cmd.bit_test_en) begin
      st_d.bit_test = pick_bit(data_bus_in, cmd.bit_sel);
    end
  end

  // Reset loads constants; a low clock enable freezes every flop
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_q.acc <= `DAP_ACC_RST;
      st_q.carry <= 1'b0;
      st_q.product_holding_reg <= `DAP_PROD_RST;
      st_q.multiplier_operand_reg <= `DAP_OPND_RST;
      st_q.store_data <= 16'h0000;
      st_q.store_valid <= 1'b0;
      st_q.bit_test <= 1'b0;
      st_q.norm_done <= 1'b0;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  // Accumulator, its low half as branch target, and carry
  assign accum = st_q.acc;
  assign branch_target = st_q.acc[15:0];
  assign carry = st_q.carry;

  // Multiplier registers
  assign product_out = st_q.product_holding_reg;
  assign operand_out = st_q.multiplier_operand_reg;

  // Store and test results
  assign store_data = st_q.store_data;
  assign store_valid = st_q.store_valid;
  assign bit_test = st_q.bit_test;
  assign norm_done = st_q.norm_done;
endmodule // dap_datapath

// >>> dap_dec_model.sv
/*
 Decoder side model: passes the command on, drives the data bus while used.
 Assumes the bench changes inputs shortly after the rising clock edge.
*/
`timescale 1ns/1ns
module dap_dec_model (
  input wire logic clock,
  input wire dap_pkg::dap_cmd_s cmd_i,
  input wire logic [15:0] data_i,
  output dap_pkg::dap_cmd_s cmd,
  output logic [15:0] data_bus_in
);
  import dap_pkg::*;
  logic [15:0] last_q = 16'h0000;
  always_ff @(posedge clock) last_q <= data_bus_in;
  assign cmd = cmd_i;
  // Released bus shows the inverse of its last value
  assign data_bus_in = (cmd_i.alu_en | cmd_i.load_opnd | cmd_i.bit_test_en) ? data_i : ~last_q;
endmodule // dap_dec_model

// >>> dap_datapath_properties.sv
/*
 Port checker of the datapath.
 Assumes one clock domain and binding to dap_datapath.
*/
`timescale 1ns/1ns
module dap_chk (
  input wire logic clock,
  input wire logic nrst,
  input wire logic clk_en,
  input wire dap_pkg::dap_cmd_s cmd,
  input wire logic [15:0] data_bus_in,
  input wire logic [15:0] prog_bus_in,
  input wire logic [15:0] status_word_one,
  input wire logic [31:0] accum,
  input wire logic [15:0] branch_target,
  input wire logic [31:0] product_out,
  input wire logic [15:0] operand_out,
  input wire logic store_valid,
  input wire logic bit_test
);
  import dap_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  logic [31:0] ext;
  logic [31:0] shf;
  logic signed [31:0] pm;
  logic sel_bit;
  assign ext = status_word_one[10] ? {{16{data_bus_in[15]}}, data_bus_in}
    : {16'h0000, data_bus_in};
  assign shf = ext << ((cmd.shift_amt > 5'h10) ? 5'h10 : cmd.shift_amt);
  assign pm = $signed(operand_out) * $signed(prog_bus_in);
  assign sel_bit = data_bus_in[4'hF - cmd.bit_sel];
  sequence s_mul;
    clk_en && cmd.mult_en && cmd.mult_signed && !cmd.load_opnd;
  endsequence
  sequence s_mac;
    s_mul ##1 clk_en && cmd.alu_en && cmd.alu_op == DAP_OP_ADD
      && cmd.src_sel == DAP_SRC_PRODUCT && cmd.product_shift_select == DAP_PSH_NONE;
  endsequence
  a_store_pulse: assert property (clk_en && cmd.store_en |=> store_valid)
    else $error("store pulse missing");
  a_acc_kept: assert property (clk_en && cmd.store_en && !cmd.alu_en |=> $stable(accum))
    else $error("store changed accumulator");
  a_branch_tgt: assert property (clk_en && cmd.alu_en && cmd.alu_op == DAP_OP_LOAD
    && cmd.src_sel == DAP_SRC_SHIFTER |=> branch_target == $past(shf[15:0]))
    else $error("branch target differs");
  a_opnd_load: assert property (clk_en && cmd.load_opnd
    |=> operand_out == $past(data_bus_in))
    else $error("operand register wrong");
  a_mult_sgn: assert property (s_mul |=> product_out == $past(pm))
    else $error("signed product wrong");
  a_load_shift: assert property (clk_en && cmd.alu_en && cmd.alu_op == DAP_OP_LOAD
    && cmd.src_sel == DAP_SRC_SHIFTER |=> accum == $past(shf))
    else $error("scaled load wrong");
  a_mac_sum: assert property (s_mac |=> accum == $past(accum) + $past(product_out))
    else $error("multiply accumulate wrong");
  a_bit_test: assert property (clk_en && cmd.bit_test_en |=> bit_test == $past(sel_bit))
    else $error("bit test wrong");
endmodule // dap_chk
bind dap_datapath dap_chk u_dap_chk (.clock, .nrst, .clk_en, .cmd, .data_bus_in, .prog_bus_in,
  .status_word_one, .accum, .branch_target, .product_out, .operand_out, .store_valid, .bit_test);

// >>> dsp_alu_shifter_multiplier_tb_top.sv
/*
 Self-checking bench of the datapath against a behavioural model.
 Assumes one result per enabled clock, one cycle after the command.
*/
`timescale 1ns/1ns
module dsp_alu_shifter_multiplier_tb_top;
  import dap_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic clk_en = 1'b1;
  dap_cmd_s c = '0;
  dap_cmd_s cmd;
  logic [15:0] d = 16'h0000, p = 16'h0000, sw = 16'h0000;
  logic [15:0] dbus, branch_target, operand_out, store_data;
  logic [31:0] accum, product_out, m_acc = '0, m_prod = '0;
  logic [15:0] m_op = '0, m_st = '0;
  logic carry, store_valid, bit_test, norm_done, m_c = 1'b0, m_sv = 1'b0, m_bt = 1'b0, m_nd = 1'b0;
  int n_mismatch = 0, checked = 0;
  always #50 clock = ~clock;
  dap_dec_model u_dap_dec_model (.clock, .cmd_i(c), .data_i(d), .cmd, .data_bus_in(dbus));
  dap_datapath u_dap_datapath (.clock, .nrst, .clk_en, .cmd, .data_bus_in(dbus), .prog_bus_in(p),
    .status_word_one(sw), .accum, .branch_target, .carry, .product_out, .operand_out,
    .store_data, .store_valid, .bit_test, .norm_done);
  task automatic stop_test();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic step();
    logic [31:0] b, w;
    logic [115:0] got, exp;
    @(posedge clock);
    #2;
    if (clk_en) begin
      w = sw[10] ? {{16{d[15]}}, d} : {16'h0000, d};
      b = w << ((c.shift_amt > 5'h10) ? 5'h10 : c.shift_amt);
      if (c.src_sel == DAP_SRC_PRODUCT) begin
        case (c.product_shift_select)
          DAP_PSH_NONE: b = m_prod;
          DAP_PSH_L1: b = m_prod << 1;
          DAP_PSH_L4: b = m_prod << 4;
          default: b = $signed(m_prod) >>> 6;
        endcase
      end
      m_sv = c.store_en;
      w = m_acc << c.store_shift;
      if (c.store_en) m_st = c.store_upper ? w[31:16] : w[15:0];
      if (c.bit_test_en) m_bt = d[4'hF - c.bit_sel];
      if (c.mult_en && c.mult_signed) m_prod = $signed(m_op) * $signed(p);
      else if (c.mult_en) m_prod = m_op * p;
      if (c.load_opnd) m_op = d;
      if (c.alu_en) begin
        case (c.alu_op)
          DAP_OP_LOAD: m_acc = b;
          DAP_OP_ADD: {m_c, m_acc} = m_acc + b;
          DAP_OP_SUB: {m_c, m_acc} = {1'b1, m_acc} - b;
          DAP_OP_AND: m_acc = m_acc & b;
          DAP_OP_OR: m_acc = m_acc | b;
          DAP_OP_XOR: m_acc = m_acc ^ b;
          DAP_OP_ABS: m_acc = m_acc[31] ? -m_acc : m_acc;
          DAP_OP_NORM: begin
            m_nd = m_acc == 0 || m_acc[31] != m_acc[30];
            if (!m_nd) m_acc = m_acc << 1;
          end
          DAP_OP_ZERO: m_acc = '0;
          default: ;
        endcase
      end
    end
    got = {accum, branch_target, carry, product_out, operand_out, store_data, store_valid,
      bit_test, norm_done};
    exp = {m_acc, m_acc[15:0], m_c, m_prod, m_op, m_st, m_sv, m_bt, m_nd};
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  initial begin
    void'($urandom(32'h90E87ADA));
    repeat (20) @(posedge clock);
    #2;
    nrst = 1'b1;
    c.load_opnd = 1'b1;
    d = 16'h0003;
    step();
    c = '0;
    c.mult_en = 1'b1;
    c.mult_signed = 1'b1;
    p = 16'hFFFE;
    step();
    c = '0;
    c.alu_en = 1'b1;
    c.alu_op = DAP_OP_ADD;
    c.src_sel = DAP_SRC_PRODUCT;
    step();
    $display("walk test done");
    repeat (600) begin
      c = dap_cmd_s'(26'($urandom));
      c.alu_op = dap_alu_op_e'(4'($urandom % 10));
      d = 16'($urandom);
      p = 16'($urandom);
      sw = 16'($urandom);
      clk_en = ($urandom % 6) != 0;
      step();
    end
    $display("random test done");
    nrst = 1'b0;
    clk_en = 1'b1;
    c = '0;
    {m_acc, m_prod, m_op, m_st, m_c, m_sv, m_bt, m_nd} = '0;
    repeat (3) @(posedge clock);
    #2;
    nrst = 1'b1;
    step();
    c.alu_en = 1'b1;
    c.alu_op = DAP_OP_LOAD;
    c.shift_amt = 5'h04;
    d = 16'h8001;
    step();
    $display("reset test done");
    stop_test();
  end
endmodule // dsp_alu_shifter_multiplier_tb_top
